// [include/pisc_pkg.sv]
// Shared constants and types for the phrase index memory controller
`default_nettype none
package pisc_pkg;
    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [19:0] INDEX_BASE = 20'h00000; // First index byte
    localparam logic [7:0] INDEX_TOP = 8'hff; // Last index byte
    localparam logic [19:0] DATA_BASE = 20'h00100; // First voice byte
    localparam logic [19:0] MAX_ADDR = 20'h1ffff; // Four 256 Kbit parts
    localparam logic [2:0] SLOT_LAST_BYTE = 3'h2; // Bytes 0..2 used, 3 unused
    localparam logic [2:0] LOAD_LAST_BYTE = 3'h5; // Start 0..2, stop 3..5
    localparam logic [1:0] SLOT_SHIFT = 2'h0; // Low bits of a slot base

    // ------------------------------------------------------------
    // Reset values and fixed pin levels
    // ------------------------------------------------------------
    localparam logic [1:0] RATE_8K = 2'h0; // Bit rate after clear
    localparam logic [14:0] STANDBY_REQUEST_ADDR = 15'h0002; // Address bit 1 high
    localparam logic [3:0] BANK_IDLE = 4'hf; // All bank selects inactive
    localparam logic [1:0] STOP_COUNT_END = 2'h2; // Stops that end playback
    localparam int CLOCK_PERIOD_NS = 10; // 100 MHz

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_CLR, S_INIT, S_WAIT, S_RIDX, S_REC, S_RSTOP,
        S_PLD, S_PLAY, S_BUMP, S_DMA, S_STANDBY_REQUEST
    } pisc_state_t;
endpackage : pisc_pkg
`default_nettype wire

// [logic/pisc_top.sv]
// Phrase index voice memory controller
`timescale 1ns/1ps
`default_nettype none
module pisc_top (
    input wire logic clock, // 100 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire logic clkEn, // Freezes all state when low
    input wire logic asyncClearN, // Clear input, active low
    input wire logic startReq, // Start pulse
    input wire logic stopReq, // Stop pulse
    input wire logic recWaitReq, // Go to recording waiting
    input wire logic playWaitReq, // Go to playback waiting
    input wire logic [5:0] phraseSel, // Phrase number for next start
    input wire logic cfgLoad, // Load rate and detector enable
    input wire logic [1:0] cfgRate, // Bit rate code
    input wire logic cfgOvfEn, // Overflow detector enable
    input wire logic standbyReq, // Standby request level
    input wire logic hostRdN, // Host read strobe
    input wire logic hostWrN, // Host write strobe
    output logic [3:0] hostNibbleOut, // Status nibble to host
    output logic hostNibbleOe, // Nibble bus driven
    output logic [14:0] sramAddr, // Memory address lines
    output logic sramAddrOe, // Address lines driven
    output logic [7:0] sramDataOut, // Memory write data
    input wire logic [7:0] sramDataIn, // Memory read data
    output logic sramDataOe, // Data lines driven
    output logic [3:0] sramBankSelN, // Bank selects, active low
    output logic sramBankSelOe, // Bank selects driven
    output logic sramWriteSelN, // Write select, active low
    output logic sramWriteSelOe, // Write select driven
    input wire logic [7:0] recData, // Voice byte to record
    input wire logic recValid, // Voice byte offered
    output logic recReady, // Voice byte taken
    output logic [7:0] playData, // Voice byte played
    output logic playValid, // Played byte valid
    input wire logic playReady, // Receiver takes byte
    output logic endOfSeq, // End of sequence output
    output logic busy, // Busy status
    output logic overflowFlag, // Overflow status
    output logic [1:0] bitRate, // Selected bit rate
    output logic oscRun, // Oscillator enable
    output logic pullEnable // Input pulls connected
);
    import pisc_pkg::*;

    pisc_state_t state;
    logic ph; // Second half of a memory access
    logic [2:0] byteIdx;
    logic [7:0] idxCnt;
    logic [5:0] phrR;
    logic recMode;
    logic [1:0] stopCnt;
    logic stopPend;
    logic [19:0] cntR;
    logic [19:0] stopR;
    logic [19:0] startR;
    logic ovfEn;
    logic cmpFf;
    logic [7:0] tailR;
    logic tailValid;
    logic accNxt;
    logic wrNxt;
    logic [19:0] aNxt;
    logic [7:0] dNxt;
    logic recAccept;
    logic ovfHit;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Slot helpers
    // ------------------------------------------------------------
    // Bytes 0..2 of phrase p, or 3..5 mapping onto slot p+1
    function automatic logic [19:0] slotAddr(input logic [5:0] p, input logic [2:0] b);
        logic [5:0] q;
        logic [1:0] o;
        q = (b > SLOT_LAST_BYTE) ? 6'(p + 6'h1) : p;
        o = (b > SLOT_LAST_BYTE) ? 2'(b - 3'h3) : b[1:0];
        slotAddr = INDEX_BASE | {12'h000, q, SLOT_SHIFT} | {18'h00000, o};
    endfunction : slotAddr

    function automatic logic [7:0] slotByte(input logic [19:0] a, input logic [1:0] b);
        unique case (b)
            2'h0: slotByte = a[7:0];
            2'h1: slotByte = a[15:8];
            default: slotByte = {4'h0, a[19:16]};
        endcase
    endfunction : slotByte

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    // Access set up in the first half, active on the pins in the second
    assign recAccept = state == S_REC && !ph && recValid && recReady;
    assign ovfHit = ovfEn && cntR == MAX_ADDR;
    assign push = state == S_PLAY && ph;
    assign pop = playValid && playReady;

    always_comb begin
        accNxt = 1'b0;
        wrNxt = 1'b0;
        aNxt = cntR;
        dNxt = 8'h00;
        unique case (state)
            S_INIT: begin
                accNxt = !ph;
                wrNxt = 1'b1;
                aNxt = {12'h000, idxCnt};
            end
            S_RIDX, S_RSTOP: begin
                accNxt = !ph;
                wrNxt = 1'b1;
                aNxt = slotAddr(phrR, (state == S_RSTOP) ? 3'(byteIdx + 3'h3) : byteIdx);
                dNxt = slotByte(cntR, byteIdx[1:0]);
            end
            S_REC: begin
                accNxt = recAccept;
                wrNxt = 1'b1;
                dNxt = recData;
            end
            S_PLD: begin
                accNxt = !ph;
                aNxt = slotAddr(phrR, byteIdx);
            end
            S_PLAY: accNxt = !ph && !tailValid && stopCnt != STOP_COUNT_END;
            default: accNxt = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Clear input wins over everything else
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= S_CLR;
            ph <= 1'b0;
            byteIdx <= 3'h0;
            idxCnt <= 8'h00;
            phrR <= 6'h00;
            recMode <= 1'b0;
        end else if (clkEn) begin
            ph <= asyncClearN && accNxt;
            if (!asyncClearN) begin
                state <= S_CLR;
            end else begin
                unique case (state)
                    S_CLR: begin
                        state <= S_INIT;
                        idxCnt <= 8'h00;
                        recMode <= 1'b0;
                    end
                    S_INIT: if (ph) begin
                        idxCnt <= idxCnt + 8'h01;
                        if (idxCnt == INDEX_TOP) state <= S_WAIT;
                    end
                    S_WAIT: begin
                        byteIdx <= 3'h0;
                        if (!hostRdN && !hostWrN) begin
                            state <= S_DMA;
                        end else if (standbyReq) begin
                            state <= S_STANDBY_REQUEST;
                        end else if (startReq) begin
                            phrR <= phraseSel;
                            state <= recMode ? S_RIDX : S_PLD;
                        end else if (recWaitReq) begin
                            recMode <= 1'b1;
                        end else if (playWaitReq) begin
                            recMode <= 1'b0;
                        end
                    end
                    S_RIDX, S_RSTOP: if (ph) begin
                        byteIdx <= byteIdx + 3'h1;
                        if (byteIdx == SLOT_LAST_BYTE) begin
                            byteIdx <= 3'h0;
                            state <= (state == S_RIDX) ? S_REC : S_BUMP;
                        end
                    end
                    S_REC: begin
                        if (ph && ovfHit) state <= S_RSTOP;
                        else if (!ph && stopPend && !recAccept) state <= S_RSTOP;
                    end
                    S_PLD: if (ph) begin
                        byteIdx <= byteIdx + 3'h1;
                        if (byteIdx == LOAD_LAST_BYTE) begin
                            // Zero start means the slot was never recorded
                            state <= (startR == 20'h00000) ? S_WAIT : S_PLAY;
                        end
                    end
                    S_PLAY: begin
                        if (!ph && stopCnt == STOP_COUNT_END) state <= S_BUMP;
                        // Match on the advanced count: ends with the counter at stop, bump makes stop+1
                        else if (ph && cmpFf && 20'(cntR + 20'h00001) == stopR)
                            state <= S_BUMP;
                    end
                    S_BUMP: state <= S_WAIT;
                    S_DMA: if (hostRdN && hostWrN) state <= S_WAIT;
                    S_STANDBY_REQUEST: if (!standbyReq) state <= S_WAIT;
                endcase
            end
        end
    end

    // Stop requests counted during playback, latched as pending during recording
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stopCnt <= 2'h0;
            stopPend <= 1'b0;
        end else if (clkEn) begin
            stopPend <= state == S_REC && (stopPend || stopReq);
            if (state != S_PLAY) stopCnt <= 2'h0;
            else if (stopReq && stopCnt != STOP_COUNT_END) stopCnt <= stopCnt + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Address counter and stop register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cntR <= DATA_BASE;
            stopR <= DATA_BASE;
            startR <= 20'h00000;
        end else if (clkEn) begin
            if (state == S_CLR) begin
                cntR <= DATA_BASE;
                stopR <= DATA_BASE;
            end else if (state == S_BUMP) begin
                cntR <= cntR + 20'h00001;
            end else if (ph && state == S_REC && !ovfHit) begin
                cntR <= cntR + 20'h00001;
            end else if (ph && state == S_PLAY) begin
                cntR <= cntR + 20'h00001;
            end else if (ph && state == S_PLD) begin
                unique case (byteIdx)
                    3'h0: startR[7:0] <= sramDataIn;
                    3'h1: startR[15:8] <= sramDataIn;
                    3'h2: startR[19:16] <= sramDataIn[3:0];
                    3'h3: stopR[7:0] <= sramDataIn;
                    3'h4: stopR[15:8] <= sramDataIn;
                    default: begin
                        stopR[19:16] <= sramDataIn[3:0];
                        // Unrecorded slot keeps the counter, so a later recording stays clear of the index
                        if (startR != 20'h00000) cntR <= startR;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Memory pins
    // ------------------------------------------------------------
    // Standby and hand-off override normal drive
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sramAddr <= 15'h0000;
            sramAddrOe <= 1'b1;
            sramDataOut <= 8'h00;
            sramDataOe <= 1'b0;
            sramBankSelN <= BANK_IDLE;
            sramBankSelOe <= 1'b1;
            sramWriteSelN <= 1'b1;
            sramWriteSelOe <= 1'b1;
        end else if (clkEn) begin
            if (state == S_STANDBY_REQUEST) begin
                sramAddr <= STANDBY_REQUEST_ADDR;
                sramAddrOe <= 1'b1;
                sramDataOut <= 8'h00;
                sramDataOe <= 1'b1;
                sramBankSelN <= BANK_IDLE;
                sramBankSelOe <= 1'b1;
                sramWriteSelN <= 1'b0;
                sramWriteSelOe <= 1'b1;
            end else begin
                sramAddr <= aNxt[14:0];
                sramAddrOe <= state != S_DMA;
                sramDataOut <= dNxt;
                sramDataOe <= state != S_DMA && accNxt && wrNxt;
                sramBankSelN <= accNxt ? ~(4'h1 << aNxt[16:15]) : BANK_IDLE;
                sramBankSelOe <= state != S_DMA;
                sramWriteSelN <= !(accNxt && wrNxt);
                sramWriteSelOe <= state != S_DMA;
            end
        end
    end

    // ------------------------------------------------------------
    // Voice byte paths
    // ------------------------------------------------------------
    // Record side takes one byte per write slot
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            recReady <= 1'b0;
        end else if (clkEn) begin
            recReady <= asyncClearN && !stopReq && !stopPend &&
                ((state == S_RIDX && ph && byteIdx == SLOT_LAST_BYTE) ||
                 (state == S_REC && ph && !ovfHit) ||
                 (state == S_REC && !ph && !recAccept));
        end
    end

    // Two-entry buffer; fetch stalls while the back entry is full
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            playData <= 8'h00;
            playValid <= 1'b0;
            tailR <= 8'h00;
            tailValid <= 1'b0;
        end else if (clkEn) begin
            if (pop) begin
                playData <= tailR;
                playValid <= tailValid;
                tailValid <= 1'b0;
            end
            if (push) begin
                if (pop ? !tailValid : !playValid) begin
                    playData <= sramDataIn;
                    playValid <= 1'b1;
                end else begin
                    tailR <= sramDataIn;
                    tailValid <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status and configuration
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b1;
            endOfSeq <= 1'b1;
            overflowFlag <= 1'b0;
            bitRate <= RATE_8K;
            ovfEn <= 1'b1;
            cmpFf <= 1'b0;
            oscRun <= 1'b1;
            pullEnable <= 1'b1;
            hostNibbleOut <= 4'h0;
            hostNibbleOe <= 1'b0;
        end else if (clkEn) begin
            busy <= !asyncClearN || state == S_CLR || state == S_INIT;
            endOfSeq <= state == S_WAIT || state == S_DMA || state == S_STANDBY_REQUEST;
            oscRun <= state != S_STANDBY_REQUEST;
            pullEnable <= state != S_STANDBY_REQUEST;
            hostNibbleOut <= {1'b0, overflowFlag, busy, endOfSeq};
            // Read strobe first: drive status until write falls
            hostNibbleOe <= !hostRdN && hostWrN && state != S_DMA;
            if (state == S_CLR) begin
                overflowFlag <= 1'b0;
                bitRate <= RATE_8K;
                ovfEn <= 1'b1;
                cmpFf <= 1'b0;
            end else begin
                if (state == S_REC && ph && ovfHit) overflowFlag <= 1'b1;
                if (state == S_WAIT && cfgLoad) begin
                    bitRate <= cfgRate;
                    ovfEn <= cfgOvfEn;
                end
                if (state == S_PLD) cmpFf <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    data_region_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (state == S_REC && accNxt) |-> aNxt >= DATA_BASE)
        else $error("voice write inside index region");
    start_slot_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (state == S_RIDX && ph && byteIdx == 3'h0) |->
        sramAddr == {7'h00, phrR, 2'h0} && sramDataOut == cntR[7:0] && !sramWriteSelN)
        else $error("start address not written to slot");
    end_bump_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (state == S_BUMP && asyncClearN) |=> cntR == $past(cntR) + 20'h00001 && state == S_WAIT)
        else $error("counter not bumped at end");
    play_load_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        $rose(state == S_PLAY) |-> $past(state) == S_PLD && $past(byteIdx) == LOAD_LAST_BYTE)
        else $error("playback without index load");
    two_stop_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (state == S_PLAY && !ph && stopCnt != STOP_COUNT_END && asyncClearN) |=> state == S_PLAY)
        else $error("playback left before second stop");
    dma_float_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (state == S_DMA) |=> !sramAddrOe && !sramDataOe && !sramBankSelOe && !sramWriteSelOe)
        else $error("memory pins driven during hand-off");
    nib_drive_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (!hostRdN && hostWrN && state != S_DMA) |=> hostNibbleOe ##0 hostNibbleOut[2] == $past(busy))
        else $error("status nibble not driven");
    standby_pins_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (state == S_STANDBY_REQUEST) |=> sramBankSelN == BANK_IDLE && sramAddr == STANDBY_REQUEST_ADDR &&
        endOfSeq && !sramWriteSelN && !oscRun && !pullEnable)
        else $error("standby pin levels wrong");
    clear_busy_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        !asyncClearN |=> busy && state == S_CLR && !recReady)
        else $error("clear did not halt");
    init_preset_a: assert property (@(posedge clock) disable iff (!nrst || !clkEn)
        (state == S_CLR && asyncClearN) |=> cntR == DATA_BASE && stopR == DATA_BASE &&
        state == S_INIT && ovfEn && !overflowFlag && bitRate == RATE_8K)
        else $error("post-clear preset wrong");
endmodule : pisc_top
`default_nettype wire

// [tb/pisc_sram_model.sv]
// Behavioural static RAM banks facing the controller
`timescale 1ns/1ps
`default_nettype none
module pisc_sram_model (
    input wire logic clock, // System clock
    input wire logic [14:0] addr, // Address lines
    input wire logic [3:0] selN, // Bank selects, active low
    input wire logic selOe, // Selects driven
    input wire logic wrN, // Write select, active low
    input wire logic [7:0] din, // Byte from controller
    output logic [7:0] dout // Byte to controller
);
    logic [7:0] mem [0:131071];
    logic [7:0] last = 8'h00;
    logic [1:0] bk;
    logic on;
    // Deselected lines show the inverse of the last byte so a stale value never matches
    assign bk = !selN[0] ? 2'h0 : !selN[1] ? 2'h1 : !selN[2] ? 2'h2 : 2'h3;
    assign on = selOe && (selN != 4'hf);
    assign dout = (on && wrN) ? mem[{bk, addr}] : ~last;
    // Writes land on the edge; read bytes are remembered for the idle pattern
    always @(posedge clock) begin
        if (on && !wrN) mem[{bk, addr}] <= din;
        if (on) last <= dout;
    end
endmodule : pisc_sram_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the phrase index memory controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pisc_pkg::*;
    logic clock = 1'b0, nrst = 1'b0, clearN = 1'b1, hostRdN = 1'b1, hostWrN = 1'b1;
    logic standbyReq = 1'b0, recValid = 1'b0, playReady = 1'b0;
    logic [4:0] req = 5'h0;
    logic [5:0] phraseSel = 6'h0;
    logic [1:0] cfgRate = 2'h0, bitRate;
    logic [7:0] recData = 8'h00, memIn, memOut, playData;
    logic [14:0] sramAddr;
    logic [3:0] selN, nib;
    logic nibOe, aOe, dOe, sOe, wsN, wOe, recReady, playValid, endOfSeq, busy;
    logic overflowFlag, oscRun, pullEnable;
    int miscompares = 0, totalChecks = 0, i, n;
    pisc_top dut (.clock, .nrst, .clkEn(1'b1), .asyncClearN(clearN), .startReq(req[0]),
        .stopReq(req[1]), .recWaitReq(req[2]), .playWaitReq(req[3]), .phraseSel,
        .cfgLoad(req[4]), .cfgRate, .cfgOvfEn(1'b1), .standbyReq, .hostRdN, .hostWrN,
        .hostNibbleOut(nib), .hostNibbleOe(nibOe), .sramAddr, .sramAddrOe(aOe),
        .sramDataOut(memOut), .sramDataIn(memIn), .sramDataOe(dOe), .sramBankSelN(selN),
        .sramBankSelOe(sOe), .sramWriteSelN(wsN), .sramWriteSelOe(wOe), .recData,
        .recValid, .recReady, .playData, .playValid, .playReady, .endOfSeq, .busy,
        .overflowFlag, .bitRate, .oscRun, .pullEnable);
    pisc_sram_model sram (.clock, .addr(sramAddr), .selN, .selOe(sOe), .wrN(wsN),
        .din(memOut), .dout(memIn));
    initial forever #5 clock = ~clock;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        totalChecks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Bounded wait: 0 busy low, 1 end flag high, 2 record byte taken
    task automatic waitFor(input int k);
        for (n = 0; n < 3000; n++) begin
            @(posedge clock);
            if (k == 0 && busy === 1'b0 || k == 1 && endOfSeq === 1'b1) break;
            if (k == 2 && recReady === 1'b1) break;
        end
        if (n == 3000) begin
            miscompares++;
            print_verdict();
        end
    endtask : waitFor
    task automatic pulse(input int k);
        req <= 5'h01 << k;
        @(posedge clock);
        req <= 5'h00;
        @(posedge clock);
    endtask : pulse
    task automatic rec(input int cnt);
        for (i = 0; i < cnt; i++) begin
            recData <= 8'ha0 + i[7:0];
            recValid <= 1'b1;
            waitFor(2);
        end
        recValid <= 1'b0;
    endtask : rec
    // Receiver stalls for stall cycles first so the two-entry buffer can fill before draining
    task automatic play(input int base, input int cnt, input int stall);
        repeat (stall) @(posedge clock);
        playReady <= 1'b1;
        i = 0;
        for (n = 0; n < 400 && i < cnt; n++) begin
            @(posedge clock);
            if (playValid === 1'b1 && playReady) begin
                chk("played byte", {16'h0, sram.mem[base + i]}, {16'h0, playData});
                i++;
            end
        end
        chk("played count", cnt, i);
        waitFor(1);
        repeat (4) @(posedge clock);
        chk("extra byte", 0, playValid);
    endtask : play
    function automatic logic [23:0] slot(input int p);
        return {4'h0, sram.mem[p * 4 + 2][3:0], sram.mem[p * 4 + 1], sram.mem[p * 4]};
    endfunction : slot
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        for (int a = 0; a < 131072; a++) sram.mem[a] = ~a[7:0];
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        waitFor(0);
        chk("init flags", {1'b1, 1'b0, RATE_8K}, {endOfSeq, overflowFlag, bitRate});
        n = 0;
        for (int a = 0; a < 256; a++) if (sram.mem[a] !== 8'h00) n++;
        chk("dirty index bytes", 0, n);
        $display("test init done");
        pulse(2);
        phraseSel <= 6'd0;
        pulse(0);
        rec(4);
        pulse(1);
        waitFor(1);
        chk("phrase0 start", 24'h000100, slot(0));
        chk("phrase0 stop", 24'h000104, slot(1));
        chk("voice byte", 24'h0000a3, sram.mem[259]);
        phraseSel <= 6'd1;
        pulse(0);
        rec(2);
        pulse(1);
        waitFor(1);
        chk("phrase1 start", 24'h000105, slot(1));
        chk("phrase1 stop", 24'h000107, slot(2));
        $display("test record done");
        pulse(3);
        phraseSel <= 6'd0;
        pulse(0);
        play(256, 5, 30);
        phraseSel <= 6'd5;
        pulse(0);
        repeat (40) @(posedge clock);
        chk("silent phrase", 2'b01, {playValid, endOfSeq});
        playReady <= 1'b0;
        phraseSel <= 6'd0;
        pulse(0);
        repeat (30) @(posedge clock);
        pulse(1);
        repeat (10) @(posedge clock);
        chk("one stop", 0, endOfSeq);
        pulse(1);
        waitFor(1);
        playReady <= 1'b1;
        repeat (20) @(posedge clock);
        phraseSel <= 6'd1;
        pulse(0);
        play(261, 2, 0);
        pulse(2);
        phraseSel <= 6'd2;
        pulse(0);
        rec(1);
        pulse(1);
        waitFor(1);
        chk("appended start", 24'h000108, slot(2));
        $display("test playback done");
        hostRdN <= 1'b0;
        repeat (3) @(posedge clock);
        chk("status nibble", 5'h11, {nibOe, nib});
        hostWrN <= 1'b0;
        repeat (3) @(posedge clock);
        chk("floated pins", 0, {nibOe, aOe, dOe, sOe, wOe});
        hostRdN <= 1'b1;
        @(posedge clock);
        hostWrN <= 1'b1;
        repeat (3) @(posedge clock);
        $display("test handoff done");
        standbyReq <= 1'b1;
        repeat (4) @(posedge clock);
        chk("standby address", {4'hf, STANDBY_REQUEST_ADDR}, {selN, sramAddr});
        chk("standby levels", 12'h800, {endOfSeq, oscRun, pullEnable, wsN, memOut});
        standbyReq <= 1'b0;
        repeat (4) @(posedge clock);
        $display("test standby done");
        cfgRate <= 2'h3;
        pulse(4);
        chk("loaded rate", 2'h3, bitRate);
        clearN <= 1'b0;
        repeat (3) @(posedge clock);
        chk("busy in clear", 1, busy);
        clearN <= 1'b1;
        waitFor(0);
        chk("rate after clear", RATE_8K, bitRate);
        n = 0;
        for (int a = 0; a < 256; a++) if (sram.mem[a] !== 8'h00) n++;
        chk("index after clear", 0, n);
        $display("test clear done");
        print_verdict();
    end
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
